// ===== dsc_pkg.sv
// constants for the delta-sigma conversion control block
package dsc_pkg;

	// ****************************************
	// bus and field widths
	// ****************************************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 21;
	localparam int SUM_W  = 23;
	localparam int CHAN_W = 3;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFF_CTRL     = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_RESULT   = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 5'h14;

	// ****************************************
	// control and status fields
	// ****************************************
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_MODE  = 2;
	localparam int CTRL_RES   = 4;
	localparam int CTRL_CHAN  = 6;
	localparam int STAT_EOC   = 0;
	localparam int STAT_BUSY  = 1;
	localparam int STAT_NSAMP = 2;
	localparam int STAT_HOLD  = 5;
	localparam int IRQ_N      = 2;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_OVR    = 1;

	// ****************************************
	// modes and resolutions
	// ****************************************
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_MULTI  = 2'h1;
	localparam logic [1:0] MODE_CONT   = 2'h2;
	localparam logic [1:0] MODE_TURBO  = 2'h3;
	localparam logic [1:0] RES_8       = 2'h0;
	localparam logic [1:0] RES_12      = 2'h1;
	localparam logic [1:0] RES_16      = 2'h2;
	localparam logic [1:0] RES_20      = 2'h3;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ  = 250_000_000;
	localparam int unsigned RATE_8  = 384_000;
	localparam int unsigned RATE_12 = 192_000;
	localparam int unsigned RATE_16 = 48_000;
	localparam int unsigned RATE_20 = 187;
	localparam int unsigned CYC_8   = CLK_HZ / RATE_8;
	localparam int unsigned CYC_12  = CLK_HZ / RATE_12;
	localparam int unsigned CYC_16_DEF = CLK_HZ / RATE_16;
	localparam int unsigned CYC_20_DEF = CLK_HZ / RATE_20;
	localparam logic [2:0] PRIME_LAST = 3'h3;

endpackage : dsc_pkg

// ===== dsc_conv_ctrl.sv
// conversion sequencer for the delta-sigma converter
// What this block does
// - results are 16 bits at 48 ksps nominally, 20 bits at up to 187 sps.
// - lower resolutions run faster, 192 ksps at 12 bits, 384 ksps at 8.
// - a result sums the last four samples, so after an input change four samples are needed.
// - every mode starts from the start bit or the external trigger input.
// - on completion a status bit and the done output rise and hold until the result is read.
// - single mode waits idle, then runs four conversions, three priming, result after the fourth.
// - in single mode, once the result is read, the block returns to idle until the next trigger.
// - continuous mode gives its first result after priming, then one per conversion time.
// - multi mode re-primes the decimator between results and restarts on its own.
// - turbo acts as multi up to 16 bits, and at 20 bits never re-primes, running as continuous mode does.
// - the done output rises at the end of every conversion result, or stays high if the previous result is still unread.
`timescale 1ns/1ps

module dsc_conv_ctrl #(
	parameter int unsigned CYC_16 = dsc_pkg::CYC_16_DEF,
	parameter int unsigned CYC_20 = dsc_pkg::CYC_20_DEF
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// register port
	input  wire logic [dsc_pkg::ADDR_W-1:0] addr,
	input  wire logic [dsc_pkg::DATA_W-1:0] wr_data,
	input  wire logic                       wr_en,
	input  wire logic                       rd_en,
	output logic      [dsc_pkg::DATA_W-1:0] rd_data,
	// converter pins
	input  wire logic                       soc_pin,
	input  wire logic                       mod_bit,
	input  wire logic                       dma_ack,
	output logic                            eoc,
	output logic                            irq,
	output logic      [dsc_pkg::CHAN_W-1:0] mux_sel
);
	import dsc_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_HOLD} dsc_state_t;

	// ****************************************
	// state
	// ****************************************
	dsc_state_t               st_r;
	dsc_state_t               st_nxt;
	logic        [1:0]        mode_r;
	logic        [1:0]        res_r;
	logic        [CHAN_W-1:0] chan_r;
	logic        [CNT_W-1:0]  cnt_r;
	logic        [CNT_W-1:0]  acc_r;
	logic        [CNT_W-1:0]  samp_r [0:PRIME_LAST-1];
	logic        [2:0]        nsamp_r;
	logic        [2:0]        nsamp_nxt;
	logic        [SUM_W-1:0]  result_r;
	logic                     eoc_r;
	logic        [IRQ_N-1:0]  irq_stat_r;
	logic        [IRQ_N-1:0]  irq_en_r;
	logic        [IRQ_N-1:0]  irq_stat_nxt;
	logic                     irq_r;
	logic        [DATA_W-1:0] rd_data_r;
	logic                     soc_sync;
	logic                     soc_prev_r;
	logic                     mod_sync;

	// ****************************************
	// decode
	// ****************************************
	wire logic wr_ctrl   = wr_en && (addr == OFF_CTRL);
	wire logic wr_irqclr = wr_en && (addr == OFF_IRQ_CLR);
	wire logic wr_irqen  = wr_en && (addr == OFF_IRQ_EN);
	wire logic rd_result = rd_en && (addr == OFF_RESULT);
	wire logic soc_edge  = soc_sync && !soc_prev_r;
	wire logic start_req = (wr_ctrl && wr_data[CTRL_START]) || soc_edge;
	wire logic stop_req  = wr_ctrl && wr_data[CTRL_STOP];
	wire logic res_read  = rd_result || dma_ack;
	wire logic busy      = (st_r == ST_CONV);
	wire logic [CHAN_W-1:0] chan_wr = wr_data[CTRL_CHAN +: CHAN_W];
	wire logic chan_chg  = wr_ctrl && (chan_wr != chan_r);

	// conversion length per resolution
	wire logic [CNT_W-1:0] conv_len =
		(res_r == RES_8)  ? CNT_W'(CYC_8)  :
		(res_r == RES_12) ? CNT_W'(CYC_12) :
		(res_r == RES_16) ? CNT_W'(CYC_16) :
		CNT_W'(CYC_20);
	wire logic conv_end = busy && (cnt_r == conv_len - CNT_W'(1));

	// ****************************************
	// decimator
	// ****************************************
	wire logic [CNT_W-1:0] raw_new = acc_r + CNT_W'(mod_sync);
	wire logic [SUM_W-1:0] sum_new = SUM_W'(raw_new) + SUM_W'(samp_r[0])
		+ SUM_W'(samp_r[1]) + SUM_W'(samp_r[2]);
	// result valid only once three priming samples are held
	wire logic res_valid = conv_end && (nsamp_r == PRIME_LAST);
	// multi re-primes; turbo too, except at 20 bits
	wire logic flush_after = (mode_r == MODE_MULTI) ||
		((mode_r == MODE_TURBO) && (res_r != RES_20));

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: begin
				if (start_req) begin
					st_nxt = ST_CONV;
				end
			end
			ST_CONV: begin
				// further starts ignored here
				if (res_valid && (mode_r == MODE_SINGLE)) begin
					st_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (res_read) begin
					st_nxt = ST_IDLE;
				end
			end
		endcase
		if (stop_req) begin
			st_nxt = ST_IDLE;
		end
	end

	always_comb begin
		nsamp_nxt = nsamp_r;
		if (conv_end) begin
			if (res_valid && flush_after) begin
				nsamp_nxt = '0;
			end else if (nsamp_r != PRIME_LAST) begin
				nsamp_nxt = nsamp_r + 3'h1;
			end
		end
		if (chan_chg || stop_req || (st_r == ST_IDLE)) begin
			nsamp_nxt = '0;
		end
	end

	// ****************************************
	// interrupt status
	// ****************************************
	wire logic overrun = res_valid && eoc_r && !res_read;
	wire logic [IRQ_N-1:0] irq_ev =
		(IRQ_N'(res_valid) << IRQ_DONE) |
		(IRQ_N'(overrun)   << IRQ_OVR);
	wire logic [IRQ_N-1:0] irq_clr =
		wr_irqclr ? wr_data[IRQ_N-1:0] : '0;
	assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

	// ****************************************
	// read mux
	// ****************************************
	wire logic [DATA_W-1:0] ctrl_rd =
		(DATA_W'(mode_r) << CTRL_MODE) |
		(DATA_W'(res_r)  << CTRL_RES)  |
		(DATA_W'(chan_r) << CTRL_CHAN);
	wire logic [DATA_W-1:0] stat_rd =
		(DATA_W'(eoc_r)           << STAT_EOC)   |
		(DATA_W'(busy)            << STAT_BUSY)  |
		(DATA_W'(nsamp_r)         << STAT_NSAMP) |
		(DATA_W'(st_r == ST_HOLD) << STAT_HOLD);
	wire logic [DATA_W-1:0] rd_mux =
		(addr == OFF_CTRL)     ? ctrl_rd :
		(addr == OFF_STATUS)   ? stat_rd :
		(addr == OFF_RESULT)   ? DATA_W'(result_r) :
		(addr == OFF_IRQ_STAT) ? DATA_W'(irq_stat_r) :
		(addr == OFF_IRQ_EN)   ? DATA_W'(irq_en_r) :
		'0;

	// ****************************************
	// pin synchronisers
	// ****************************************
	dsc_sync2 u_soc_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (soc_pin),
		.sync  (soc_sync)
	);

	dsc_sync2 u_mod_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (mod_bit),
		.sync  (mod_sync)
	);

	// ****************************************
	// registers
	// ****************************************
	// previous trigger level for the edge detector
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soc_prev_r <= 1'b0;
		end else begin
			soc_prev_r <= soc_sync;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_r <= MODE_SINGLE;
			res_r  <= RES_16;
			chan_r <= '0;
		end else if (wr_ctrl) begin
			mode_r <= wr_data[CTRL_MODE +: 2];
			res_r  <= wr_data[CTRL_RES +: 2];
			chan_r <= chan_wr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r    <= ST_IDLE;
			nsamp_r <= '0;
			cnt_r   <= '0;
			acc_r   <= '0;
		end else begin
			st_r    <= st_nxt;
			nsamp_r <= nsamp_nxt;
			cnt_r   <= (!busy || conv_end) ? '0 : cnt_r + CNT_W'(1);
			acc_r   <= (!busy || conv_end) ? '0 : raw_new;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < int'(PRIME_LAST); i++) begin
				samp_r[i] <= '0;
			end
		end else if (conv_end) begin
			samp_r[0] <= raw_new;
			for (int i = 1; i < int'(PRIME_LAST); i++) begin
				samp_r[i] <= samp_r[i-1];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_r <= '0;
			eoc_r    <= 1'b0;
		end else begin
			if (res_valid) begin
				result_r <= sum_new;
			end
			// a new result wins over a read in the same cycle
			eoc_r <= res_valid || (eoc_r && !res_read);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_stat_r <= '0;
			irq_en_r   <= '0;
			irq_r      <= 1'b0;
			rd_data_r  <= '0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			irq_en_r   <= wr_irqen ? wr_data[IRQ_N-1:0] : irq_en_r;
			irq_r      <= |(irq_stat_r & irq_en_r);
			rd_data_r  <= rd_en ? rd_mux : '0;
		end
	end

	assign rd_data = rd_data_r;
	assign eoc     = eoc_r;
	assign irq     = irq_r;
	assign mux_sel = chan_r;

endmodule : dsc_conv_ctrl

// ****************************************
// two-flop synchroniser for an asynchronous pin
// ****************************************
module dsc_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// pin in, synchronised level out
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sync
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// only the second stage is read outside
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
		end
	end

	assign sync = sync_r;

endmodule : dsc_sync2

// ===== dsc_conv_ctrl_asserts.sv
// port checker for the conversion sequencer
`timescale 1ns/1ps
module dsc_conv_ctrl_chk (
	// clock and reset
	input wire logic                       clk,
	input wire logic                       rst_n,
	// register port
	input wire logic [dsc_pkg::ADDR_W-1:0] addr,
	input wire logic [dsc_pkg::DATA_W-1:0] wr_data,
	input wire logic                       wr_en,
	input wire logic                       rd_en,
	input wire logic [dsc_pkg::DATA_W-1:0] rd_data,
	// converter pins
	input wire logic                       dma_ack,
	input wire logic                       eoc,
	input wire logic                       irq,
	input wire logic [dsc_pkg::CHAN_W-1:0] mux_sel
);
	import dsc_pkg::*;
	logic [CHAN_W-1:0] chan_w;
	assign chan_w = wr_data[CTRL_CHAN+:CHAN_W];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ****************************************
	// properties
	// ****************************************
	property p_rd_zero; !rd_en |=> rd_data == '0; endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("read data not zero");
	property p_unmap; rd_en && addr > OFF_IRQ_EN |=> rd_data == '0; endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_stat;
		rd_en && addr == OFF_STATUS |=> rd_data[STAT_EOC] == $past(eoc);
	endproperty
	a_stat: assert property (p_stat)
		else $error("status done bit wrong");
	property p_hold; eoc && !rd_en && !wr_en && !dma_ack |=> eoc; endproperty
	a_hold: assert property (p_hold)
		else $error("done dropped unread");
	property p_rdclr; eoc && rd_en && addr == OFF_RESULT |=> !eoc; endproperty
	a_rdclr: assert property (p_rdclr)
		else $error("done kept after read");
	property p_ackclr; eoc && dma_ack |=> !eoc; endproperty
	a_ackclr: assert property (p_ackclr)
		else $error("done kept after dma");
	property p_mux; wr_en && addr == OFF_CTRL |=> mux_sel == $past(chan_w);
	endproperty
	a_mux: assert property (p_mux)
		else $error("channel select wrong");
	property p_irq;
		$rose(irq) |-> $past(eoc) || $past(wr_en) || $past(wr_en, 2);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt without cause");
endmodule : dsc_conv_ctrl_chk
bind dsc_conv_ctrl dsc_conv_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .dma_ack(dma_ack), .eoc(eoc), .irq(irq),
	.mux_sel(mux_sel));

// ===== dsc_dma_model.sv
// dma responder that fetches each result after a delay
`timescale 1ns/1ps
module dsc_dma_model (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// bench control
	input wire logic       en,
	input wire logic [3:0] dly,
	// done handshake
	input wire logic       eoc,
	output logic           dma_ack
);
	logic [3:0] cnt_r;
	always_ff @(posedge clk) begin
		if (!rst_n || !en || !eoc || dma_ack) begin
			cnt_r   <= 4'h0;
			dma_ack <= 1'b0;
		end else begin
			cnt_r   <= cnt_r + 4'h1;
			dma_ack <= (cnt_r == dly);
		end
	end
endmodule : dsc_dma_model

// ===== dsc_conv_ctrl_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module dsc_conv_ctrl_tb;
	import dsc_pkg::*;
	localparam int     N16 = 40;
	logic              clk = 0, rst_n = 0, wr_en = 0, rd_en = 0;
	logic              soc_pin = 0, mod_bit = 1, dma_on = 0;
	logic              dma_ack, eoc, irq;
	logic [3:0]        dly = 4'h0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wr_data = '0, rd_data, d;
	logic [CHAN_W-1:0] mux_sel;
	int                n_errors = 0, n_tests = 0, cyc = 0, t0, t1, t2;
	int                tab [6][3] = '{'{32'h29, 4*N16, N16},
		'{32'h25, 4*N16, 4*N16}, '{32'h2D, 4*N16, 4*N16}, '{32'h3D, 240, 60},
		'{32'h0D, 4*CYC_8, 4*CYC_8}, '{32'h15, 4*CYC_12, 4*CYC_12}};
	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	dsc_conv_ctrl #(.CYC_16(N16), .CYC_20(60)) dut (.clk(clk), .rst_n(rst_n),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .soc_pin(soc_pin), .mod_bit(mod_bit),
		.dma_ack(dma_ack), .eoc(eoc), .irq(irq), .mux_sel(mux_sel));
	dsc_dma_model u_dma (.clk(clk), .rst_n(rst_n), .en(dma_on), .dly(dly),
		.eoc(eoc), .dma_ack(dma_ack));
	// ****************************************
	// tasks
	// ****************************************
	task results;
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		wr_en   <= 1'b1;
		addr    <= a;
		wr_data <= v;
		@(posedge clk);
		wr_en <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : wr
	task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
		@(posedge clk);
	endtask : rd
	task rise(output int t);
		@(negedge clk);
		for (int i = 0; i < 6000 && eoc !== 1'b0; i++) begin
			@(negedge clk);
		end
		for (int i = 0; i < 6000 && eoc !== 1'b1; i++) begin
			@(negedge clk);
		end
		t = cyc;
		chk("eoc", 1, eoc);
		@(posedge clk);
	endtask : rise
	initial begin
		#200000;
		n_errors++;
		results;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("eoc", 0, eoc);
		chk("mux_sel", 0, mux_sel);
		rd(5'h1C, d);
		chk("unmapped", 0, d);
		wr(OFF_IRQ_EN, 32'h1);
		t0 = cyc;
		wr(OFF_CTRL, 32'h161);
		chk("mux_sel", 5, mux_sel);
		repeat (20) @(posedge clk);
		wr(OFF_CTRL, 32'h161);
		rise(t1);
		chk("latency", 1, (t1 - t0) inside {[159:166]});
		repeat (10) @(posedge clk);
		chk("eoc", 1, eoc);
		chk("irq", 1, irq);
		rd(OFF_STATUS, d);
		chk("status", 32'h21, d & 32'h21);
		rd(OFF_RESULT, d);
		chk("result", 4 * N16, d);
		chk("eoc", 0, eoc);
		wr(OFF_IRQ_EN, 32'h0);
		chk("irq", 0, irq);
		wr(OFF_IRQ_EN, 32'h1);
		chk("irq", 1, irq);
		wr(OFF_IRQ_CLR, 32'h1);
		chk("irq", 0, irq);
		rd(OFF_IRQ_STAT, d);
		chk("irq_stat", 0, d);
		repeat (300) @(posedge clk);
		chk("eoc", 0, eoc);
		t0 = cyc;
		soc_pin <= 1'b1;
		rise(t1);
		soc_pin <= 1'b0;
		chk("soc", 1, (t1 - t0) inside {[160:172]});
		rd(OFF_RESULT, d);
		dma_on <= 1'b1;
		foreach (tab[i]) begin
			dly <= 4'(i * 3);
			t0 = cyc;
			wr(OFF_CTRL, tab[i][0]);
			rise(t1);
			rise(t2);
			chk("first", 1, (t1 - t0) inside {[tab[i][1]-1:tab[i][1]+6]});
			chk("gap", 1, (t2 - t1) inside {[tab[i][2]:tab[i][2]+2]});
			wr(OFF_CTRL, 32'h2);
		end
		repeat (20) @(posedge clk);
		dma_on <= 1'b0;
		wr(OFF_IRQ_CLR, 32'h3);
		wr(OFF_CTRL, 32'h25);
		rise(t1);
		rd(OFF_RESULT, d);
		repeat (60) @(posedge clk);
		wr(OFF_CTRL, 32'h64);
		chk("mux_sel", 1, mux_sel);
		rise(t2);
		chk("reprime", 1, (t2 - t1) inside {[5*N16:5*N16+2]});
		repeat (165) @(posedge clk);
		rd(OFF_IRQ_STAT, d);
		chk("irq_stat", 32'h3, d);
		wr(OFF_CTRL, 32'h2);
		rd(OFF_RESULT, d);
		results;
	end
endmodule : dsc_conv_ctrl_tb
